// >>> src/scec_params.svh
// offsets, field positions, reset values of the serial control enable block
// assumes a 32-bit axi4-lite port, word-aligned
`ifndef SCEC_PARAMS_SVH
`define SCEC_PARAMS_SVH

// register byte offsets
`define SCEC_OFS_CTRL      8'h00
`define SCEC_OFS_PORTMODE  8'h04
`define SCEC_OFS_STATUS    8'h08
`define SCEC_OFS_IRQ_STAT  8'h0c
`define SCEC_OFS_IRQ_CLR   8'h10
`define SCEC_OFS_IRQ_EN    8'h14

// control register fields
`define SCEC_CTRL_CKE0     0
`define SCEC_CTRL_CKE1     1
`define SCEC_CTRL_TEIE     2
`define SCEC_CTRL_MPIE     3
`define SCEC_CTRL_RE       4
`define SCEC_CTRL_TE       5
`define SCEC_CTRL_RIE      6
`define SCEC_CTRL_TIE      7
`define SCEC_CTRL_SYNC     8
`define SCEC_CTRL_W        9
`define SCEC_CTRL_RST      9'h000

// port mode register fields
`define SCEC_PM_TXD_SEL    0
`define SCEC_PM_GP_OUT     1
`define SCEC_PM_GP_OE      2
`define SCEC_PM_W          3
`define SCEC_PM_RST        3'h0

// status register fields
`define SCEC_ST_RECEIVE_FULL_FLAG       0
`define SCEC_ST_FER        1
`define SCEC_ST_OER        2
`define SCEC_ST_TDRE       3
`define SCEC_ST_TEND       4
`define SCEC_ST_RXD_LVL    8
`define SCEC_ST_CKE_RSVD   9

// interrupt status layout: one bit per request
`define SCEC_IRQ_TEND      0
`define SCEC_IRQ_TXE       1
`define SCEC_IRQ_RXF       2
`define SCEC_IRQ_RXERR     3
`define SCEC_IRQ_W         4
`define SCEC_IRQ_RST       4'h0

`endif

// >>> src/scec_pkg.sv
// types shared by the serial control enable block
// assumes scec_params.svh supplies offsets and fields
package scec_pkg;

    // axi4-lite response codes
    typedef enum logic [1:0] {
        SCEC_RESP_OKAY   = 2'b00,
        SCEC_RESP_SLVERR = 2'b10
    } scec_resp_t;

    // asynchronous / clocked selection of the control register
    typedef enum logic {
        SCEC_MODE_ASYNC = 1'b0,
        SCEC_MODE_SYNC  = 1'b1
    } scec_mode_t;

endpackage

// >>> src/scec_rx_filter.sv
// multiprocessor receive filter: decides which frame results reach the flags
// assumes one-cycle frame_done pulses from the receive shift engine
`timescale 1ns/1ps
module scec_rx_filter (
    scec_rx_if.filter rx
);

    // a frame counts while reception is enabled, unless the filter is armed and the frame is not addressed
    logic accept;

    always_comb begin
        accept      = rx.frame_done && rx.re && (!rx.mpie || rx.mp_bit);
        rx.mpie_clr = rx.frame_done && rx.re && rx.mpie && rx.mp_bit;
        rx.receive_full_flag_set = accept && !rx.oer_in;
        rx.fer_set  = accept && rx.fer_in;
        rx.oer_set  = accept && rx.oer_in;
    end

endmodule // scec_rx_filter

// >>> src/scec_rx_if.sv
// carrier between the register top and the receive filter
// assumes both ends run on aclk
`timescale 1ns/1ps
interface scec_rx_if;
    logic frame_done;   // engine finished a frame
    logic mp_bit;       // multiprocessor bit of that frame
    logic fer_in;       // frame had a framing error
    logic oer_in;       // frame overran the buffer
    logic mpie;         // filter armed
    logic re;           // reception enabled
    logic mpie_clr;     // addressed frame seen
    logic receive_full_flag_set;
    logic fer_set;
    logic oer_set;

    modport top    (output frame_done, mp_bit, fer_in, oer_in, mpie, re,
                    input  mpie_clr, receive_full_flag_set, fer_set, oer_set);
    modport filter (input  frame_done, mp_bit, fer_in, oer_in, mpie, re,
                    output mpie_clr, receive_full_flag_set, fer_set, oer_set);
endinterface // scec_rx_if

// >>> src/scec_top.sv
// control-register enable logic of a serial interface, with axi4-lite slave
// assumes shift engines and baud logic outside, joined by flags and requests
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "scec_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - transmit-end request only while its enable is 1.
// - multiprocessor enable 0: every frame sets flags and requests.
// - multiprocessor enable clears itself when a frame with mp bit 1 arrives.
// - multiprocessor enable 1: receive flags and requests held off until addressed frame.
// - receive enable 0: no reception, input pin is a plain port.
// - receive enable 1: input pin feeds the receiver.
// - transmit enable 0: nothing is sent.
// - transmit enable 1 with pin select 1: output pin drives transmit data.
// - output pin carries transmit data only with pin select 1.
// - receive interrupt enable gates both receive requests.
// - transmit interrupt enable 0: no transmit-empty request.
module scec_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // receive engine
    input  wire logic        rx_frame_done,
    input  wire logic        rx_mp_bit,
    input  wire logic        rx_framing_err,
    input  wire logic        rx_overrun,
    output logic             rx_serial_in,
    output logic             rx_enable,
    // transmit engine
    input  wire logic        tx_serial_out,
    input  wire logic        tx_buf_empty,
    input  wire logic        tx_end,
    input  wire logic        tx_load,
    output logic             tx_go,
    output logic             tx_enable,
    // serial pins
    input  wire logic        rxd_pin_in,
    output logic             txd_pin_out,
    output logic             txd_pin_oe,
    // interrupt requests and flags
    output logic             transmit_end_irq,
    output logic             transmit_empty_irq,
    output logic             receive_full_irq,
    output logic             receive_error_irq,
    output logic             receive_full_flag,
    output logic             framing_error_flag,
    output logic             overrun_error_flag,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [`SCEC_CTRL_W-1:0] ctrl_reg;
    logic [`SCEC_PM_W-1:0]   port_mode_reg_seven;
    logic [`SCEC_IRQ_W-1:0]  irq_stat_reg;
    wire logic [`SCEC_IRQ_W-1:0] irq_stat_next;
    logic [`SCEC_IRQ_W-1:0]  irq_en_reg;
    logic [`SCEC_IRQ_W-1:0]  irq_event;
    logic [7:0]              awaddr_reg;
    logic [31:0]             wdata_reg;
    logic [3:0]              wstrb_reg;
    logic                    aw_have_reg;
    logic                    w_have_reg;
    logic                    wr_fire;
    logic                    rxd_meta_reg;
    logic                    rxd_sync_reg;
    logic                    cke_rsvd;
    logic [31:0]             status_word;

    scec_rx_if rxb ();

    // decode of mapped word offsets, shared by write and read paths
    function automatic logic scec_mapped(input logic [7:0] a);
        scec_mapped = (a[1:0] == 2'b00) && (a <= `SCEC_OFS_IRQ_EN);
    endfunction

    // merge a byte-lane write into a narrow register
    function automatic logic [31:0] scec_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        scec_merge = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: aw and w in either order

    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

    // address and data holding registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    // write response, slverr for unmapped offsets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= scec_pkg::SCEC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= scec_mapped(awaddr_reg) ? scec_pkg::SCEC_RESP_OKAY : scec_pkg::SCEC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register; mpie also cleared by an addressed frame

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `SCEC_CTRL_RST;
        end else begin
            if (wr_fire && awaddr_reg == `SCEC_OFS_CTRL) begin
                ctrl_reg <= (`SCEC_CTRL_W)'(scec_merge({23'h0, ctrl_reg}, wdata_reg, wstrb_reg));
            end
            // hardware clear last so the addressed frame is never lost
            if (rxb.mpie_clr) begin
                ctrl_reg[`SCEC_CTRL_MPIE] <= 1'b0;
            end
        end
    end

    // port mode register: pin select plus plain port drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_mode_reg_seven <= `SCEC_PM_RST;
        end else if (wr_fire && awaddr_reg == `SCEC_OFS_PORTMODE) begin
            port_mode_reg_seven <= (`SCEC_PM_W)'(scec_merge({29'h0, port_mode_reg_seven}, wdata_reg, wstrb_reg));
        end
    end

    // reserved clock-enable combinations only reported, never acted on
    always_comb begin
        if (ctrl_reg[`SCEC_CTRL_SYNC] == scec_pkg::SCEC_MODE_SYNC) begin
            cke_rsvd = ctrl_reg[`SCEC_CTRL_CKE0];
        end else begin
            cke_rsvd = ctrl_reg[`SCEC_CTRL_CKE1] && ctrl_reg[`SCEC_CTRL_CKE0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive filter hookup

    assign rxb.frame_done = rx_frame_done;
    assign rxb.mp_bit     = rx_mp_bit;
    assign rxb.fer_in     = rx_framing_err;
    assign rxb.oer_in     = rx_overrun;
    assign rxb.mpie       = ctrl_reg[`SCEC_CTRL_MPIE];
    assign rxb.re         = ctrl_reg[`SCEC_CTRL_RE];

    scec_rx_filter u_filter (
        .rx (rxb)
    );

    // receive flags: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            receive_full_flag  <= 1'b0;
            framing_error_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
        end else begin
            if (rxb.receive_full_flag_set) begin
                receive_full_flag <= 1'b1;
            end else if (wr_fire && awaddr_reg == `SCEC_OFS_STATUS && wstrb_reg[0] && wdata_reg[`SCEC_ST_RECEIVE_FULL_FLAG]) begin
                receive_full_flag <= 1'b0;
            end
            if (rxb.fer_set) begin
                framing_error_flag <= 1'b1;
            end else if (wr_fire && awaddr_reg == `SCEC_OFS_STATUS && wstrb_reg[0] && wdata_reg[`SCEC_ST_FER]) begin
                framing_error_flag <= 1'b0;
            end
            if (rxb.oer_set) begin
                overrun_error_flag <= 1'b1;
            end else if (wr_fire && awaddr_reg == `SCEC_OFS_STATUS && wstrb_reg[0] && wdata_reg[`SCEC_ST_OER]) begin
                overrun_error_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt requests, gated by the control enables

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transmit_end_irq   <= 1'b0;
            transmit_empty_irq <= 1'b0;
            receive_full_irq   <= 1'b0;
            receive_error_irq  <= 1'b0;
        end else begin
            transmit_end_irq   <= ctrl_reg[`SCEC_CTRL_TEIE] && tx_end;
            transmit_empty_irq <= ctrl_reg[`SCEC_CTRL_TIE] && tx_buf_empty;
            // flags already filtered, so the filter also holds these off
            receive_full_irq   <= ctrl_reg[`SCEC_CTRL_RIE] && receive_full_flag;
            receive_error_irq  <= ctrl_reg[`SCEC_CTRL_RIE]
                                  && (framing_error_flag || overrun_error_flag);
        end
    end

    assign irq_event = {receive_error_irq, receive_full_irq, transmit_empty_irq, transmit_end_irq};

    // sticky status per request; a new event beats a clear
    genvar g;
    generate
        for (g = 0; g < `SCEC_IRQ_W; g++) begin : g_irq
            assign irq_stat_next[g] = irq_event[g]
                || (irq_stat_reg[g] && !(wr_fire && awaddr_reg == `SCEC_OFS_IRQ_CLR && wstrb_reg[0] && wdata_reg[g]));
        end
    endgenerate

    // one writer for the whole vector
    always_ff @(posedge aclk) begin
        irq_stat_reg <= aresetn ? irq_stat_next : `SCEC_IRQ_RST;
    end

    // interrupt enable register and combined level output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_reg <= `SCEC_IRQ_RST;
            irq        <= 1'b0;
        end else begin
            if (wr_fire && awaddr_reg == `SCEC_OFS_IRQ_EN && wstrb_reg[0]) begin
                irq_en_reg <= wdata_reg[`SCEC_IRQ_W-1:0];
            end
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and engine enables

    // two-stage synchroniser on the receive pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            rxd_meta_reg <= rxd_pin_in;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // receiver sees idle-high when disabled, so no false start bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_enable    <= 1'b0;
            rx_serial_in <= 1'b1;
        end else begin
            rx_enable    <= ctrl_reg[`SCEC_CTRL_RE];
            rx_serial_in <= ctrl_reg[`SCEC_CTRL_RE] ? rxd_sync_reg : 1'b1;
        end
    end

    // transmitter enable and load gating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_enable <= 1'b0;
            tx_go     <= 1'b0;
        end else begin
            tx_enable <= ctrl_reg[`SCEC_CTRL_TE];
            tx_go     <= ctrl_reg[`SCEC_CTRL_TE] && tx_load;
        end
    end

    // output pin: serial data only with te and pin select, else plain port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txd_pin_out <= 1'b0;
            txd_pin_oe  <= 1'b0;
        end else if (ctrl_reg[`SCEC_CTRL_TE] && port_mode_reg_seven[`SCEC_PM_TXD_SEL]) begin
            txd_pin_out <= tx_serial_out;
            txd_pin_oe  <= 1'b1;
        end else begin
            txd_pin_out <= port_mode_reg_seven[`SCEC_PM_GP_OUT];
            txd_pin_oe  <= port_mode_reg_seven[`SCEC_PM_GP_OE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read path: one read at a time, answered next cycle

    always_comb begin
        status_word                    = 32'h0000_0000;
        status_word[`SCEC_ST_RECEIVE_FULL_FLAG]     = receive_full_flag;
        status_word[`SCEC_ST_FER]      = framing_error_flag;
        status_word[`SCEC_ST_OER]      = overrun_error_flag;
        status_word[`SCEC_ST_TDRE]     = tx_buf_empty;
        status_word[`SCEC_ST_TEND]     = tx_end;
        status_word[`SCEC_ST_RXD_LVL]  = rxd_sync_reg;
        status_word[`SCEC_ST_CKE_RSVD] = cke_rsvd;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= scec_pkg::SCEC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= scec_mapped(s_axi_araddr) ? scec_pkg::SCEC_RESP_OKAY : scec_pkg::SCEC_RESP_SLVERR;
                unique case (s_axi_araddr)
                    `SCEC_OFS_CTRL:     s_axi_rdata <= {23'h0, ctrl_reg};
                    `SCEC_OFS_PORTMODE: s_axi_rdata <= {29'h0, port_mode_reg_seven};
                    `SCEC_OFS_STATUS:   s_axi_rdata <= status_word;
                    `SCEC_OFS_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_reg};
                    `SCEC_OFS_IRQ_EN:   s_axi_rdata <= {28'h0, irq_en_reg};
                    default:            s_axi_rdata <= 32'h0000_0000; // clear reg and holes
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // scec_top

// >>> verification/scec_props.sv
// checker on the top module's ports
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module scec_props (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // register bus handshakes
    input logic s_axi_awready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    // engines
    input logic rx_frame_done,
    input logic rx_enable,
    input logic rx_serial_in,
    input logic tx_end,
    input logic tx_buf_empty,
    input logic tx_load,
    input logic tx_go,
    input logic tx_enable,
    // requests and flags
    input logic transmit_end_irq,
    input logic transmit_empty_irq,
    input logic receive_full_irq,
    input logic receive_error_irq,
    input logic receive_full_flag,
    input logic framing_error_flag,
    input logic overrun_error_flag
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    // read: answer a cycle after the address
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_answer;
        s_axi_rvalid;
    endsequence
    property p_rd_lat; s_ar_taken |=> s_rd_answer; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("late read answer");
    property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");

    ////////////////////////////////////////////////////////////////////////////
    // requests follow causes a cycle late
    property p_tend; transmit_end_irq |-> $past(tx_end); endproperty
    a_tend: assert property (p_tend) else $error("stray end request");
    property p_txe; transmit_empty_irq |-> $past(tx_buf_empty); endproperty
    a_txe: assert property (p_txe) else $error("stray empty request");
    property p_rxf; receive_full_irq |-> $past(receive_full_flag); endproperty
    a_rxf: assert property (p_rxf) else $error("stray full request");
    property p_rxerr; receive_error_irq |-> $past(framing_error_flag || overrun_error_flag); endproperty
    a_rxerr: assert property (p_rxerr) else $error("stray error request");
    // flags rise only on frames
    property p_flag;
        ($rose(receive_full_flag) || $rose(framing_error_flag) || $rose(overrun_error_flag))
            |-> $past(rx_frame_done && rx_enable);
    endproperty
    a_flag: assert property (p_flag) else $error("flag without frame");
    property p_rxpin; !rx_enable |-> rx_serial_in; endproperty
    a_rxpin: assert property (p_rxpin) else $error("rx input live when off");
    property p_txgo; tx_go |-> $past(tx_load); endproperty
    a_txgo: assert property (p_txgo) else $error("go without load");
    // covers the enable copy's lag
    property p_txoff; (!tx_enable && !$past(tx_enable)) |-> !tx_go; endproperty
    a_txoff: assert property (p_txoff) else $error("go while disabled");
endmodule // scec_props

bind scec_top scec_props u_props (.*);

// >>> verification/scec_station.sv
// remote station model: hands finished frames to the receive side
// assumes one frame request at a time, on aclk edges
`timescale 1ns/1ps
module scec_station (
    // bench side
    input  logic aclk,
    input  logic send,
    input  logic mp,
    input  logic fe,
    input  logic ov,
    // device side
    output logic      rx_frame_done,
    output logic      rx_mp_bit,
    output logic      rx_framing_err,
    output logic      rx_overrun
);
    // qualifiers toggle outside the pulse, so nothing may lean on them
    always @(posedge aclk) begin
        rx_frame_done  <= send;
        rx_mp_bit      <= send ? mp : ~rx_mp_bit;
        rx_framing_err <= send ? fe : ~rx_framing_err;
        rx_overrun     <= send ? ov : ~rx_overrun;
    end
endmodule // scec_station

// >>> verification/testbench.sv
// self-checking bench for the serial control enable block
// assumes outputs settle within three cycles of a cause
`timescale 1ns/1ps
`include "scec_params.svh"
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, send = 1'b0, mp = 1'b0, fe = 1'b0, ov = 1'b0;
    int fails = 0, total_checks = 0, cycles = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, tx_serial_out = 1'b0, tx_buf_empty = 1'b0, tx_end = 1'b0;
    logic tx_load = 1'b0, rxd_pin_in = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rx_frame_done, rx_mp_bit, rx_framing_err, rx_overrun, rx_serial_in, rx_enable;
    logic tx_go, tx_enable, txd_pin_out, txd_pin_oe, transmit_end_irq, transmit_empty_irq;
    logic receive_full_irq, receive_error_irq, receive_full_flag, framing_error_flag;
    logic overrun_error_flag, irq;
    logic [31:0] d;
    logic [1:0] r;

    scec_top dut (.*);
    scec_station u_station (.*);

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // write: aw and w together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'b111};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic frame(input logic m, input logic f, input logic o);
        {send, mp, fe, ov} <= {1'b1, m, f, o};
        @(posedge aclk);
        send <= 1'b0;
        step(4);
    endtask
    function automatic logic [2:0] flags();
        return {receive_full_flag, framing_error_flag, overrun_error_flag};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(`SCEC_OFS_CTRL);
        chk(d, 32'h0);
        rd(`SCEC_OFS_IRQ_STAT);
        chk(d, 32'h0);
        rd(8'h40);
        chk(d, 32'h0);
        chk(r, scec_pkg::SCEC_RESP_SLVERR);
        wr(8'h40, 32'h1);
        chk(r, scec_pkg::SCEC_RESP_SLVERR);
    endtask
    task automatic t_tend();
        tx_end <= 1'b1;
        wr(`SCEC_OFS_CTRL, 32'h0);
        chk(transmit_end_irq, 1'b0);
        wr(`SCEC_OFS_CTRL, 32'h4);
        step(3);
        chk(transmit_end_irq, 1'b1);
        wr(`SCEC_OFS_IRQ_EN, 32'h1);
        step(3);
        chk(irq, 1'b1);
        wr(`SCEC_OFS_IRQ_EN, 32'h0);
        step(3);
        chk(irq, 1'b0);
        tx_end <= 1'b0;
        step(3);
        wr(`SCEC_OFS_IRQ_CLR, 32'hf);
        rd(`SCEC_OFS_IRQ_STAT);
        chk(d, 32'h0);
        tx_buf_empty <= 1'b1;
        step(3);
        chk(transmit_empty_irq, 1'b0);
        wr(`SCEC_OFS_CTRL, 32'h80);
        step(3);
        chk(transmit_empty_irq, 1'b1);
        tx_buf_empty <= 1'b0;
        step(3);
        chk(transmit_empty_irq, 1'b0);
    endtask
    task automatic t_rx();
        wr(`SCEC_OFS_CTRL, 32'h50);
        frame(1'b0, 1'b0, 1'b0);
        chk({flags(), receive_full_irq}, 4'b1001);
        frame(1'b0, 1'b1, 1'b1);
        chk({flags(), receive_error_irq}, 4'b1111);
        wr(`SCEC_OFS_CTRL, 32'h10);
        step(3);
        chk({receive_full_irq, receive_error_irq}, 2'b00);
        wr(`SCEC_OFS_STATUS, 32'h7);
        step(3);
        chk(flags(), 3'b000);
    endtask
    task automatic t_mp();
        wr(`SCEC_OFS_CTRL, 32'h58);
        frame(1'b0, 1'b1, 1'b1);
        chk({flags(), receive_error_irq}, 4'b0000);
        frame(1'b1, 1'b0, 1'b0);
        chk(flags(), 3'b100);
        rd(`SCEC_OFS_CTRL);
        chk(d[3], 1'b0);
        wr(`SCEC_OFS_STATUS, 32'h7);
        frame(1'b0, 1'b0, 1'b0);
        chk(flags(), 3'b100);
        wr(`SCEC_OFS_STATUS, 32'h7);
    endtask
    task automatic t_rxoff();
        wr(`SCEC_OFS_CTRL, 32'h0);
        rxd_pin_in <= 1'b0;
        frame(1'b0, 1'b1, 1'b0);
        chk({flags(), rx_serial_in, rx_enable}, 5'b00010);
        wr(`SCEC_OFS_CTRL, 32'h10);
        step(4);
        chk({rx_serial_in, rx_enable}, 2'b01);
        rxd_pin_in <= 1'b1;
        step(4);
        chk(rx_serial_in, 1'b1);
    endtask
    task automatic t_tx();
        tx_load <= 1'b1;
        wr(`SCEC_OFS_CTRL, 32'h0);
        step(3);
        chk(tx_go, 1'b0);
        wr(`SCEC_OFS_PORTMODE, 32'h6);
        wr(`SCEC_OFS_CTRL, 32'h20);
        step(3);
        chk({tx_go, tx_enable, txd_pin_oe, txd_pin_out}, 4'b1111);
        wr(`SCEC_OFS_PORTMODE, 32'h7);
        step(3);
        chk({txd_pin_oe, txd_pin_out}, 2'b10);
        tx_serial_out <= 1'b1;
        step(3);
        chk(txd_pin_out, 1'b1);
        tx_load <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, far above the run's length
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        step(20);
        aresetn <= 1'b1;
        t_regs();
        t_tend();
        t_rx();
        t_mp();
        t_rxoff();
        t_tx();
        print_verdict();
    end
endmodule // testbench
